// ===== bench/cbsb_testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench import cbsb_pkg::*;;
    // Expected outcome of one retired instruction
    typedef struct {
        int cyc;
        logic [15:0] pc;
        logic cy;
        logic [7:0] sp;
        logic we;
        logic bt;
        logic [7:0] ad;
        logic [7:0] dt;
    } cbsb_exp_t;

    logic clock_i = 1'b0; // System clock
    logic rst_i = 1'b1; // Held high from time zero
    logic req_valid_i = 1'b0; // Request offered
    cbsb_req_t req_i = '0; // Decoded request
    logic ready_o, done_o, carry_o;
    logic [15:0] pc_o;
    logic [7:0] sp_o;
    cbsb_wr_t wr_o;
    int n_errors = 0, comparisons = 0, cycle = 0, last_cyc = 0;
    integer seed = 32'hde94; // Fixed seed keeps runs repeatable
    logic [31:0] r;
    logic [15:0] m_pc = 16'h0000; // Reference program counter
    logic m_cy = 1'b0; // Reference carry
    logic [7:0] m_sp = 8'h07; // Reference stack pointer
    cbsb_exp_t q[$]; // Notes of results still to retire
    cbsb_exp_t x; // Oldest note under comparison

    cbsb_core DUT (.clock_i(clock_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o),
        .done_o(done_o), .pc_o(pc_o), .carry_o(carry_o), .sp_o(sp_o),
        .wr_o(wr_o));

    // 100 MHz clock
    always #5 clock_i = ~clock_i;

    // Cycle count; a hang ends the run here
    always @(posedge clock_i) begin
        cycle <= cycle + 1;
        if (cycle == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // Offer one op, wait until taken, note its expected outcome
    task automatic run_op(cbsb_op_t op, logic [7:0] v, logic [7:0] im,
                          logic [7:0] rl, logic [7:0] ad, logic bv);
        cbsb_exp_t e;
        logic [15:0] ofs;
        int n;
        @(negedge clock_i);
        // A two-cycle op must refuse the very next request
        if (last_cyc == 2) check("ready_o", 16'(ready_o), 16'h0000);
        req_valid_i = 1'b1;
        req_i = '{op, v, im, rl, ad, bv};
        n = 0;
        while (ready_o !== 1'b1 && n < 8) begin
            @(negedge clock_i);
            n++;
        end
        ofs = {{8{rl[7]}}, rl};
        e = '{0, m_pc, m_cy, m_sp, 1'b0, 1'b0, ad, 8'h00};
        // Lengths and cycle counts per op class
        e.pc += (op inside {CBSB_NOP, CBSB_CLR_C, CBSB_SET_BIT_OP_C, CBSB_CPL_C})
            ? 16'h0001 : (op inside {CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_COMPARE_JUMP_NOT_EQUAL_IND,
            CBSB_DECREMENT_JUMP_NOT_ZERO_DIR}) ? 16'h0003 : 16'h0002;
        last_cyc = (op inside {CBSB_NOP, CBSB_CLR_C, CBSB_SET_BIT_OP_C, CBSB_CPL_C,
            CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_DECREMENT_JUMP_NOT_ZERO_REG}) ? 1 : 2;
        // Taking edge bumps the count once, so retire lands last_cyc on
        e.cyc = cycle + last_cyc;
        case (op)
            CBSB_NOP: ;
            CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_COMPARE_JUMP_NOT_EQUAL_IND: begin
                e.cy = v < im;
                if (v != im) e.pc += ofs;
            end
            CBSB_DECREMENT_JUMP_NOT_ZERO_REG, CBSB_DECREMENT_JUMP_NOT_ZERO_DIR: begin
                e.we = 1'b1;
                e.dt = v - 8'h01;
                if (e.dt != 8'h00) e.pc += ofs;
            end
            CBSB_PUSH: begin
                e.sp += 8'h01;
                e.we = 1'b1;
                e.ad = e.sp;
                e.dt = v;
            end
            CBSB_POP: begin
                e.sp -= 8'h01;
                e.we = 1'b1;
                e.dt = v;
            end
            CBSB_MOV_C_BIT: e.cy = bv;
            CBSB_CLR_C: e.cy = 1'b0;
            CBSB_SET_BIT_OP_C: e.cy = 1'b1;
            CBSB_CPL_C: e.cy = ~m_cy;
            CBSB_ANL_C_NBIT: e.cy = m_cy & ~bv;
            CBSB_ORL_C_BIT: e.cy = m_cy | bv;
            CBSB_ORL_C_NBIT: e.cy = m_cy | ~bv;
            default: begin // Bit writes: value travels in bit 0
                e.we = 1'b1;
                e.bt = 1'b1;
                e.dt = {7'h00, op == CBSB_MOV_BIT_C ? m_cy : op ==
                    CBSB_CPL_BIT ? ~bv : op == CBSB_SET_BIT_OP_BIT};
            end
        endcase
        m_pc = e.pc;
        m_cy = e.cy;
        m_sp = e.sp;
        q.push_back(e);
        @(posedge clock_i);
    endtask : run_op

    // Watch retirements and compare with the oldest note
    always @(negedge clock_i) begin
        if (!rst_i && done_o === 1'b1) begin
            if (q.size() == 0) check("spare done_o", 16'h0001, 16'h0000);
            else begin
                x = q.pop_front();
                check("done cycle", 16'(cycle), 16'(x.cyc));
                check("pc_o", pc_o, x.pc);
                check("carry_o", 16'(carry_o), 16'(x.cy));
                check("sp_o", 16'(sp_o), 16'(x.sp));
                check("we", 16'(wr_o.we), 16'(x.we));
                if (x.we) begin
                    check("is_bit", 16'(wr_o.is_bit), 16'(x.bt));
                    check("addr", 16'(wr_o.addr), 16'(x.ad));
                    check("data", 16'(x.bt ? {7'h00, wr_o.data[0]} :
                        wr_o.data), 16'(x.dt));
                end
            end
        end
        else if (!rst_i) check("idle we", 16'(wr_o.we), 16'h0000);
    end

    // Reset, every op once, then random traffic
    initial begin
        repeat (5) @(posedge clock_i);
        check("rst pc_o", pc_o, 16'h0000);
        check("rst sp_o", 16'(sp_o), 16'h0007);
        check("rst carry", 16'(carry_o), 16'h0000);
        check("rst ready", 16'(ready_o), 16'h0000);
        @(negedge clock_i);
        rst_i = 1'b0;
        // Equal operands and a count of one: the no-branch corners
        for (int i = 0; i < 18; i++)
            run_op(cbsb_op_t'(i[4:0]), 8'h01, 8'h01, 8'hfe, 8'h30, 1'b1);
        repeat (400) begin
            r = $random(seed);
            run_op(cbsb_op_t'(5'(r[31:24] % 8'd18)), r[7:0],
                r[15] ? r[7:0] : r[23:16], r[23:16], r[15:8], r[14]);
        end
        @(negedge clock_i);
        req_valid_i = 1'b0;
        repeat (4) @(negedge clock_i);
        check("pending", 16'(q.size()), 16'h0000);
        stop_test();
    end
endmodule : testbench
`default_nettype wire

// ===== logic/cbsb_core.sv
`timescale 1ns/1ns
`default_nettype none
module cbsb_core import cbsb_pkg::*; (
    input wire logic clock_i,          // 100 MHz system clock
    input wire logic rst_i,            // Async reset, active high
    input wire logic req_valid_i,      // Request offered
    input wire cbsb_req_t req_i,       // Decoded request
    output logic ready_o,              // Ready to take a request
    output logic done_o,               // Instruction retired pulse
    output logic [15:0] pc_o,          // program_counter
    output logic carry_o,              // carry_flag
    output logic [7:0] sp_o,           // stack_pointer
    output var cbsb_wr_t wr_o          // Write-back strobe and data
);
    // Gray-coded sequencer states
    typedef enum logic [1:0] {CBSB_IDLE = 2'b00, CBSB_WAIT = 2'b01} cbsb_st_t;

    cbsb_st_t state;                   // Sequencer state
    logic acc;                         // Request taken this cycle
    logic [15:0] next_pc;              // Program counter after op
    logic next_cy;                     // Carry after op
    logic [7:0] next_sp;               // Stack pointer after op
    cbsb_wr_t next_wr;                 // Write-back of op
    logic [15:0] pend_pc;              // Held results for slow ops
    logic pend_cy;
    logic [7:0] pend_sp;
    cbsb_wr_t pend_wr;

    assign acc = req_valid_i && ready_o;

    // Operation semantics, from the offered request and the current pc_o, carry_o and sp_o
    always_comb begin
        logic [15:0] adv;
        logic [15:0] tgt;
        logic [7:0] dec;
        adv = pc_o + {14'h0000, cbsb_len(req_i.op)};
        tgt = adv + {{8{req_i.rel[7]}}, req_i.rel};
        dec = req_i.val - 8'h01;
        next_pc = adv;
        next_cy = carry_o;
        next_sp = sp_o;
        next_wr = '0;
        case (req_i.op)
            CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_COMPARE_JUMP_NOT_EQUAL_IND: begin
                // Carry tracks an unsigned below, else cleared
                next_cy = req_i.val < req_i.imm;
                if (req_i.val != req_i.imm) begin
                    next_pc = tgt;
                end
            end
            CBSB_DECREMENT_JUMP_NOT_ZERO_REG, CBSB_DECREMENT_JUMP_NOT_ZERO_DIR: begin
                // Flags untouched, byte rewritten in place
                next_wr = '{we: 1'b1, is_bit: 1'b0, addr: req_i.addr,
                            data: dec};
                if (dec != 8'h00) begin
                    next_pc = tgt;
                end
            end
            CBSB_PUSH: begin
                next_sp = sp_o + 8'h01;
                next_wr = '{we: 1'b1, is_bit: 1'b0, addr: next_sp,
                            data: req_i.val};
            end
            CBSB_POP: begin
                // val is the byte the core read at the stack pointer
                next_wr = '{we: 1'b1, is_bit: 1'b0, addr: req_i.addr,
                            data: req_i.val};
                next_sp = sp_o - 8'h01;
            end
            CBSB_MOV_C_BIT: next_cy = req_i.bitv;
            CBSB_MOV_BIT_C: begin
                next_wr = '{we: 1'b1, is_bit: 1'b1, addr: req_i.addr,
                            data: {7'h00, carry_o}};
            end
            CBSB_CLR_C: next_cy = 1'b0;
            CBSB_CLR_BIT: begin
                next_wr = '{we: 1'b1, is_bit: 1'b1, addr: req_i.addr,
                            data: 8'h00};
            end
            CBSB_SET_BIT_OP_C: next_cy = 1'b1;
            CBSB_SET_BIT_OP_BIT: begin
                next_wr = '{we: 1'b1, is_bit: 1'b1, addr: req_i.addr,
                            data: 8'h01};
            end
            CBSB_CPL_C: next_cy = ~carry_o;
            CBSB_CPL_BIT: begin
                next_wr = '{we: 1'b1, is_bit: 1'b1, addr: req_i.addr,
                            data: {7'h00, ~req_i.bitv}};
            end
            CBSB_ANL_C_NBIT: next_cy = carry_o & ~req_i.bitv;
            CBSB_ORL_C_BIT: next_cy = carry_o | req_i.bitv;
            CBSB_ORL_C_NBIT: next_cy = carry_o | ~req_i.bitv;
            default: begin
                // Empty operation: counter step only
            end
        endcase
    end

    // Sequencer; two-cycle ops hold results one extra cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= CBSB_IDLE;
            ready_o <= 1'b0;
        end else if (state == CBSB_IDLE && acc
                     && cbsb_cyc(req_i.op) == CBSB_C2) begin
            state <= CBSB_WAIT;
            ready_o <= 1'b0;
        end else begin
            state <= CBSB_IDLE;
            ready_o <= 1'b1;
        end
    end

    // Held results for the two-cycle path
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pend_pc <= CBSB_PC_RST;
            pend_cy <= CBSB_CY_RST;
            pend_sp <= CBSB_SP_RST;
            pend_wr <= '0;
        end else if (acc) begin
            pend_pc <= next_pc;
            pend_cy <= next_cy;
            pend_sp <= next_sp;
            pend_wr <= next_wr;
        end
    end

    // Architectural state and retire outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pc_o <= CBSB_PC_RST;
            carry_o <= CBSB_CY_RST;
            sp_o <= CBSB_SP_RST;
            wr_o <= '0;
            done_o <= 1'b0;
        end else if (acc && cbsb_cyc(req_i.op) == CBSB_C1) begin
            pc_o <= next_pc;
            carry_o <= next_cy;
            sp_o <= next_sp;
            wr_o <= next_wr;
            done_o <= 1'b1;
        end else if (state == CBSB_WAIT) begin
            pc_o <= pend_pc;
            carry_o <= pend_cy;
            sp_o <= pend_sp;
            wr_o <= pend_wr;
            done_o <= 1'b1;
        end else begin
            wr_o <= '0;
            done_o <= 1'b0;
        end
    end

    // Checks on retire timing and results
    sequence s_slow;
        !done_o ##1 done_o;
    endsequence

    property p_compare_jump_not_equal_reg;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_COMPARE_JUMP_NOT_EQUAL_REG |=>
            done_o && carry_o == $past(req_i.val < req_i.imm);
    endproperty
    a_compare_jump_not_equal_reg: assert property (p_compare_jump_not_equal_reg)
        else $error("register compare-jump wrong");

    property p_compare_jump_not_equal_ind;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_COMPARE_JUMP_NOT_EQUAL_IND |=> s_slow;
    endproperty
    a_compare_jump_not_equal_ind: assert property (p_compare_jump_not_equal_ind)
        else $error("indirect compare-jump timing wrong");

    property p_decrement_jump_not_zero_reg;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_DECREMENT_JUMP_NOT_ZERO_REG && req_i.val == 8'h01 |=>
            pc_o == $past(pc_o) + 16'h0002 && carry_o == $past(carry_o);
    endproperty
    a_decrement_jump_not_zero_reg: assert property (p_decrement_jump_not_zero_reg)
        else $error("decrement-jump fall-through wrong");

    property p_decrement_jump_not_zero_dir;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_DECREMENT_JUMP_NOT_ZERO_DIR |-> ##2
            wr_o.we && wr_o.data == 8'($past(req_i.val, 2) - 8'h01);
    endproperty
    a_decrement_jump_not_zero_dir: assert property (p_decrement_jump_not_zero_dir)
        else $error("direct decrement write wrong");

    property p_push;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_PUSH |=> s_slow ##0
            sp_o == 8'($past(sp_o, 2) + 8'h01) && wr_o.addr == sp_o;
    endproperty
    a_push: assert property (p_push)
        else $error("push pointer or address wrong");

    property p_pop;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_POP |=> s_slow ##0
            sp_o == 8'($past(sp_o, 2) - 8'h01);
    endproperty
    a_pop: assert property (p_pop)
        else $error("pop pointer wrong");

    property p_nop;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_NOP |=> done_o && !wr_o.we
            && pc_o == $past(pc_o) + 16'h0001 && $stable(sp_o);
    endproperty
    a_nop: assert property (p_nop)
        else $error("empty operation changed state");

    property p_cpl_c;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_CPL_C |=> carry_o != $past(carry_o);
    endproperty
    a_cpl_c: assert property (p_cpl_c)
        else $error("carry complement wrong");

    property p_orl_n;
        @(posedge clock_i) disable iff (rst_i)
        acc && req_i.op == CBSB_ORL_C_NBIT && !req_i.bitv |-> ##2
            carry_o && done_o;
    endproperty
    a_orl_n: assert property (p_orl_n)
        else $error("carry OR inverted bit wrong");
endmodule : cbsb_core
`default_nettype wire

// ===== logic/cbsb_pkg.sv
`default_nettype none
package cbsb_pkg;
    // Operations handled by this execution group
    typedef enum logic [4:0] {
        CBSB_NOP, CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_COMPARE_JUMP_NOT_EQUAL_IND, CBSB_DECREMENT_JUMP_NOT_ZERO_REG,
        CBSB_DECREMENT_JUMP_NOT_ZERO_DIR, CBSB_PUSH, CBSB_POP, CBSB_MOV_C_BIT,
        CBSB_MOV_BIT_C, CBSB_CLR_C, CBSB_CLR_BIT, CBSB_SET_BIT_OP_C,
        CBSB_SET_BIT_OP_BIT, CBSB_CPL_C, CBSB_CPL_BIT, CBSB_ANL_C_NBIT,
        CBSB_ORL_C_BIT, CBSB_ORL_C_NBIT
    } cbsb_op_t;

    // Decoded request with operand values fetched by the core
    typedef struct packed {
        cbsb_op_t op;       // Operation
        logic [7:0] val;    // Register, byte or stacked byte value
        logic [7:0] imm;    // Immediate operand
        logic [7:0] rel;    // Signed branch offset
        logic [7:0] addr;   // Register, direct or bit address
        logic bitv;         // Current value of addressed bit
    } cbsb_req_t;

    // Write-back request towards data or bit space
    typedef struct packed {
        logic we;           // One-cycle write strobe
        logic is_bit;       // Bit write, data[0] carries the bit
        logic [7:0] addr;   // Target address
        logic [7:0] data;   // Write data
    } cbsb_wr_t;

    localparam logic [15:0] CBSB_PC_RST = 16'h0000;
    localparam logic [7:0] CBSB_SP_RST = 8'h07;
    localparam logic CBSB_CY_RST = 1'b0;
    localparam logic [1:0] CBSB_B1 = 2'h1;  // One byte
    localparam logic [1:0] CBSB_B2 = 2'h2;  // Two bytes
    localparam logic [1:0] CBSB_B3 = 2'h3;  // Three bytes
    localparam logic [1:0] CBSB_C1 = 2'h1;  // One cycle
    localparam logic [1:0] CBSB_C2 = 2'h2;  // Two cycles

    // Encoded length in bytes
    function automatic logic [1:0] cbsb_len(input cbsb_op_t op);
        case (op)
            CBSB_NOP, CBSB_CLR_C, CBSB_SET_BIT_OP_C, CBSB_CPL_C: return CBSB_B1;
            CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_COMPARE_JUMP_NOT_EQUAL_IND, CBSB_DECREMENT_JUMP_NOT_ZERO_DIR: return CBSB_B3;
            default: return CBSB_B2;
        endcase
    endfunction : cbsb_len

    // Execution time in machine cycles
    function automatic logic [1:0] cbsb_cyc(input cbsb_op_t op);
        case (op)
            CBSB_NOP, CBSB_CLR_C, CBSB_SET_BIT_OP_C, CBSB_CPL_C,
            CBSB_COMPARE_JUMP_NOT_EQUAL_REG, CBSB_DECREMENT_JUMP_NOT_ZERO_REG: return CBSB_C1;
            default: return CBSB_C2;
        endcase
    endfunction : cbsb_cyc
endpackage : cbsb_pkg
`default_nettype wire
